/* verilog/fisc_top.sv */
// Identity readout and program/erase suspend control of a serial flash.
`timescale 1ns/1ps
`include "fisc_defs.svh"

module fisc_top #(
    parameter logic [23:0] ID_VALUE = `FISC_ID_DEFAULT,  // Value is arbitrary.
    parameter int          T_SUS_NS = `FISC_T_SUS_NS
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 sclk_i,
    input  wire logic                 cs_n_i,
    input  wire logic                 si_i,
    output logic                      so_o,
    output logic                      so_oe_n_o,
    input  wire logic                 op_start_i,
    input  fisc_pkg::fisc_kind_t      op_kind_i,
    input  wire logic                 op_done_i,
    input  wire logic                 op_paused_i,
    output logic                      op_pause_o,
    output logic                      op_resume_o,
    output fisc_pkg::fisc_status_t    status_o,
    output fisc_pkg::fisc_cmd_evt_t   cmd_o
);

    // Longest suspend time rounds down to whole cycles, never below one.
    localparam int SUS_CYC_RAW = (T_SUS_NS * `FISC_CLK_MHZ) / 1000;
    localparam int SUS_CYC     = (SUS_CYC_RAW < 1) ? 1 : SUS_CYC_RAW;
    localparam int SUS_W       = $clog2(SUS_CYC + 1);
    localparam logic [SUS_W-1:0] SUS_LAST = SUS_W'(SUS_CYC - 1);

    // Link side, clocked by the serial clock; all but the opcode and busy flops clear on chip select high.
    logic [2:0]  bit_cnt_q;
    logic        opc_done_q;
    logic [6:0]  opc_sh_q;
    logic [7:0]  link_opc_q;
    logic        cmd_rdy_q;
    logic        id_active_q;
    logic        blk_s1_q;
    logic        blk_s2_q;
    logic        blk_q;
    logic [23:0] id_sh_q;
    logic        id_drive_q;
    logic        so_q;

    wire         last_bit   = (bit_cnt_q == `FISC_BITCNT_LAST) && !opc_done_q;
    wire  [7:0]  opc_full   = {opc_sh_q, si_i};
    wire         is_id_opc  = (opc_full == `FISC_OP_READ_ID);

    // Busy or paused state reaches the serial side through two flops.
    always_ff @(posedge sclk_i) begin
        blk_s1_q <= blk_q;
        blk_s2_q <= blk_s1_q;
    end

    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt_q   <= 3'h0;
            opc_done_q  <= 1'b0;
            cmd_rdy_q   <= 1'b0;
            id_active_q <= 1'b0;
        end else begin
            if (!opc_done_q) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (last_bit) begin
                opc_done_q  <= 1'b1;
                cmd_rdy_q   <= 1'b1;
                id_active_q <= is_id_opc && !blk_s2_q;
            end
        end
    end

    // Opcode bits are held without a clear so the core reads a stable byte.
    always_ff @(posedge sclk_i) begin
        if (!opc_done_q) begin
            opc_sh_q <= opc_full[6:0];
        end
        if (!cs_n_i && last_bit) begin
            link_opc_q <= opc_full;
        end
    end

    // Identity leaves on falling edges; after the third byte it wraps to the first.
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            id_sh_q    <= ID_VALUE;
            id_drive_q <= 1'b0;
            so_q       <= 1'b0;
        end else if (id_active_q) begin
            so_q       <= id_sh_q[`FISC_ID_W-1];
            id_sh_q    <= {id_sh_q[`FISC_ID_W-2:0], id_sh_q[`FISC_ID_W-1]};
            id_drive_q <= 1'b1;
        end
    end

    assign so_o      = so_q;
    assign so_oe_n_o = ~id_drive_q;

    // Core side. The opcode crosses as a level plus a stable byte.
    logic                       rdy_s1_q;
    logic                       rdy_s2_q;
    logic                       rdy_s3_q;
    logic                       busy_q;
    logic                       busy_d;
    logic                       sus_pgm_q;
    logic                       sus_pgm_d;
    logic                       sus_ers_q;
    logic                       sus_ers_d;
    fisc_pkg::fisc_kind_t       run_kind_q;
    fisc_pkg::fisc_kind_t       run_kind_d;
    fisc_pkg::fisc_sus_state_t  sus_st_q;
    fisc_pkg::fisc_sus_state_t  sus_st_d;
    logic [SUS_W-1:0]           sus_cnt_q;
    logic [SUS_W-1:0]           sus_cnt_d;
    logic                       resume_q;
    fisc_pkg::fisc_cmd_evt_t    cmd_q;
    fisc_pkg::fisc_cmd_evt_t    cmd_d;
    fisc_pkg::fisc_status_t     status_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
            rdy_s3_q <= 1'b0;
        end else begin
            rdy_s1_q <= cmd_rdy_q;
            rdy_s2_q <= rdy_s1_q;
            rdy_s3_q <= rdy_s2_q;
        end
    end

    wire       cmd_evt = rdy_s2_q && !rdy_s3_q;
    wire [7:0] code    = link_opc_q;

    // Command classes used by the suspend filter.
    wire is_read = (code == `FISC_OP_READ)  || (code == `FISC_OP_READ4)
                || (code == `FISC_OP_FREAD) || (code == `FISC_OP_FREAD4)
                || (code == `FISC_OP_DIOR)  || (code == `FISC_OP_DIOR4)
                || (code == `FISC_OP_DOR)   || (code == `FISC_OP_DOR4)
                || (code == `FISC_OP_QIOR)  || (code == `FISC_OP_QIOR4)
                || (code == `FISC_OP_QOR)   || (code == `FISC_OP_QOR4);
    wire is_rdsr = (code == `FISC_OP_RDSR1) || (code == `FISC_OP_RDSR2)
                || (code == `FISC_OP_RDSR3);
    wire is_ear  = (code == `FISC_OP_RDEAR) || (code == `FISC_OP_WREAR);
    wire is_rst  = (code == `FISC_OP_RSTEN) || (code == `FISC_OP_RST);
    wire is_pp   = (code == `FISC_OP_PP)    || (code == `FISC_OP_PP4)
                || (code == `FISC_OP_QPP)   || (code == `FISC_OP_QPP4);
    wire is_wren = (code == `FISC_OP_WREN);
    wire is_sus  = (code == `FISC_OP_SUSPEND);
    wire is_res  = (code == `FISC_OP_RESUME);
    wire is_id   = (code == `FISC_OP_READ_ID);

    wire paused   = sus_pgm_q || sus_ers_q;
    // While paused, anything outside these sets but a resume is refused, which covers every erase opcode, and program opcodes in a program pause.
    wire ok_both  = is_read || is_rdsr || is_ear || is_rst;
    wire ok_ers   = is_wren || is_pp;
    wire in_prog  = busy_q && (run_kind_q != fisc_pkg::FISC_KIND_OTHER);
    wire sus_ok   = is_sus && in_prog && !paused
                 && (sus_st_q == fisc_pkg::FISC_SUS_NONE);
    // Resume waits for the suspend to settle, or its flags would be left set.
    wire res_ok   = is_res && paused && !busy_q
                 && (sus_st_q == fisc_pkg::FISC_SUS_HELD);
    wire plain_ok = !is_sus && !is_res && !(is_id && busy_q);
    wire filt_ok  = sus_ers_q ? (ok_both || ok_ers) : (ok_both);
    wire cmd_ok   = sus_ok || res_ok || (!is_sus && !is_res && (paused ? filt_ok : plain_ok));

    wire sus_take = cmd_evt && sus_ok;
    wire res_take = cmd_evt && res_ok;
    wire sus_end  = (sus_st_q == fisc_pkg::FISC_SUS_WAIT)
                 && (op_paused_i || (sus_cnt_q == SUS_LAST));

    always_comb begin
        sus_st_d   = sus_st_q;
        sus_cnt_d  = sus_cnt_q;
        sus_pgm_d  = sus_pgm_q;
        sus_ers_d  = sus_ers_q;
        busy_d     = busy_q;
        run_kind_d = run_kind_q;
        if (op_done_i) begin
            busy_d     = 1'b0;
            run_kind_d = fisc_pkg::FISC_KIND_OTHER;
        end
        unique case (sus_st_q)
            fisc_pkg::FISC_SUS_NONE: begin
                if (sus_take) begin
                    sus_st_d  = fisc_pkg::FISC_SUS_WAIT;
                    sus_cnt_d = '0;
                    sus_pgm_d = (run_kind_q == fisc_pkg::FISC_KIND_PGM);
                    sus_ers_d = (run_kind_q == fisc_pkg::FISC_KIND_ERS);
                end
            end
            fisc_pkg::FISC_SUS_WAIT: begin
                sus_cnt_d = sus_cnt_q + SUS_W'(1);
                if (sus_end) begin
                    sus_st_d = fisc_pkg::FISC_SUS_HELD;
                    busy_d   = 1'b0;
                end
            end
            fisc_pkg::FISC_SUS_HELD: begin
                if (res_take) begin
                    sus_st_d   = fisc_pkg::FISC_SUS_NONE;
                    sus_pgm_d  = 1'b0;
                    sus_ers_d  = 1'b0;
                    busy_d     = 1'b1;
                    run_kind_d = sus_pgm_q ? fisc_pkg::FISC_KIND_PGM : fisc_pkg::FISC_KIND_ERS;
                end
            end
            default: begin
                sus_st_d = fisc_pkg::FISC_SUS_NONE;
            end
        endcase
        // A start in the same cycle as a finish wins, so the new cycle stays busy.
        if (op_start_i) begin
            busy_d     = 1'b1;
            run_kind_d = op_kind_i;
        end
    end

    always_comb begin
        cmd_d.accept = cmd_evt && cmd_ok;
        cmd_d.reject = cmd_evt && !cmd_ok;
        cmd_d.code   = cmd_evt ? code : cmd_q.code;
    end

    // Reset stands for a power cycle and drops any paused operation.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sus_st_q   <= fisc_pkg::FISC_SUS_NONE;
            sus_cnt_q  <= '0;
            sus_pgm_q  <= 1'b0;
            sus_ers_q  <= 1'b0;
            busy_q     <= 1'b0;
            run_kind_q <= fisc_pkg::FISC_KIND_OTHER;
            resume_q   <= 1'b0;
            cmd_q      <= '0;
        end else begin
            sus_st_q   <= sus_st_d;
            sus_cnt_q  <= sus_cnt_d;
            sus_pgm_q  <= sus_pgm_d;
            sus_ers_q  <= sus_ers_d;
            busy_q     <= busy_d;
            run_kind_q <= run_kind_d;
            resume_q   <= res_take;
            cmd_q      <= cmd_d;
        end
    end

    always_comb begin
        status_q.write_in_progress  = busy_q;
        status_q.suspend_flag_upper = sus_pgm_q;
        status_q.suspend_flag_lower = sus_ers_q;
    end

    // The serial side sees one core flop, never a gate, so no glitch can be caught.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            blk_q <= 1'b0;
        end else begin
            blk_q <= busy_q | sus_pgm_q | sus_ers_q;
        end
    end

    assign status_o    = status_q;
    assign cmd_o       = cmd_q;
    assign op_pause_o  = (sus_st_q != fisc_pkg::FISC_SUS_NONE);
    assign op_resume_o = resume_q;

endmodule

/* inc/fisc_defs.svh */
// Opcodes, timing figures and reset values for the identity and suspend block.
`ifndef FISC_DEFS_SVH
`define FISC_DEFS_SVH

`define FISC_CLK_MHZ      250
`define FISC_T_SUS_NS     20000
`define FISC_ID_DEFAULT   24'h3c_5a_19
`define FISC_ID_W         24
`define FISC_OPC_W        8
`define FISC_BITCNT_LAST  3'h7

`define FISC_OP_READ_ID   8'h9f
`define FISC_OP_SUSPEND   8'h75
`define FISC_OP_RESUME    8'h7a
`define FISC_OP_WREN      8'h06
`define FISC_OP_RDSR1     8'h05
`define FISC_OP_RDSR2     8'h35
`define FISC_OP_RDSR3     8'h15
`define FISC_OP_RDEAR     8'hc8
`define FISC_OP_WREAR     8'hc5
`define FISC_OP_READ      8'h03
`define FISC_OP_READ4     8'h13
`define FISC_OP_FREAD     8'h0b
`define FISC_OP_FREAD4    8'h0c
`define FISC_OP_DIOR      8'hbb
`define FISC_OP_DIOR4     8'hbc
`define FISC_OP_DOR       8'h3b
`define FISC_OP_DOR4      8'h3c
`define FISC_OP_QIOR      8'heb
`define FISC_OP_QIOR4     8'hec
`define FISC_OP_QOR       8'h6b
`define FISC_OP_QOR4      8'h6c
`define FISC_OP_PP        8'h02
`define FISC_OP_PP4       8'h12
`define FISC_OP_QPP       8'h32
`define FISC_OP_QPP4      8'h34
`define FISC_OP_RSTEN     8'h66
`define FISC_OP_RST       8'h99

`endif

/* inc/fisc_pkg.sv */
// Types shared by the identity and suspend block and its users.
package fisc_pkg;

    typedef enum logic [1:0] {
        FISC_KIND_OTHER = 2'b00,
        FISC_KIND_PGM   = 2'b01,
        FISC_KIND_ERS   = 2'b10
    } fisc_kind_t;

    typedef enum logic [1:0] {
        FISC_SUS_NONE = 2'b00,
        FISC_SUS_WAIT = 2'b01,
        FISC_SUS_HELD = 2'b10
    } fisc_sus_state_t;

    typedef struct packed {
        logic write_in_progress;
        logic suspend_flag_upper;
        logic suspend_flag_lower;
    } fisc_status_t;

    typedef struct packed {
        logic       accept;
        logic       reject;
        logic [7:0] code;
    } fisc_cmd_evt_t;

endpackage

/* tb/fisc_monitor.sv */
// Checker of the identity and suspend block, bound to its top module.
`timescale 1ns/1ps
module fisc_monitor #(
    parameter int T_SUS_NS = 20000
) (
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    input wire logic               sclk_i,
    input wire logic               cs_n_i,
    input wire logic               si_i,
    input wire logic               so_o,
    input wire logic               so_oe_n_o,
    input wire logic               op_start_i,
    input fisc_pkg::fisc_kind_t    op_kind_i,
    input wire logic               op_done_i,
    input wire logic               op_paused_i,
    input wire logic               op_pause_o,
    input wire logic               op_resume_o,
    input fisc_pkg::fisc_status_t  status_o,
    input fisc_pkg::fisc_cmd_evt_t cmd_o
);
    localparam int SUS_CYC = T_SUS_NS * 250 / 1000;
    wire       busy = status_o.write_in_progress;
    wire [1:0] flg  = {status_o.suspend_flag_upper, status_o.suspend_flag_lower};
    wire       acc  = cmd_o.accept;
    wire [7:0] op   = cmd_o.code;
    logic      pause_q;
    int        wait_q;
    // Only the first wait after a pause counts, so a program inside an erase pause is exempt.
    always_ff @(posedge clk_i) begin
        pause_q <= op_pause_o;
        if (!rst_n_i || !busy || !op_pause_o) wait_q <= 0;
        else if (!pause_q || wait_q != 0) wait_q <= wait_q + 1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_sus_latency: assert property (wait_q <= SUS_CYC + 2)
        else $error("busy held too long after pause");
    a_suspend_gate: assert property (acc && op == 8'h75 |->
        $past(busy) && $past(flg) == 2'h0 && flg != 2'h0 && op_pause_o)
        else $error("suspend accepted in wrong state");
    a_resume_state: assert property (op_resume_o |->
        (busy && flg == 2'h0 && !op_pause_o) ##1 !op_resume_o)
        else $error("resume outputs wrong");
    a_resume_pulse: assert property (acc && op == 8'h7a |-> op_resume_o)
        else $error("resume accepted without resume pulse");
    a_one_flag: assert property (flg != 2'h3) else $error("both pause flags set");
    a_ident_gate: assert property (acc && op == 8'h9f |-> !$past(busy) && $past(flg) == 2'h0)
        else $error("identity accepted while busy");
    a_erase_gate: assert property (acc && op inside {8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60,
        8'h01, 8'h31, 8'h11, 8'h44} |-> $past(flg) == 2'h0) else $error("erase accepted in pause");
    a_pgm_gate: assert property (acc && op inside {8'h06, 8'h02, 8'h12, 8'h32, 8'h34, 8'h42} |->
        !$past(flg[1])) else $error("program accepted in program pause");
    a_cs_idle: assert property (cs_n_i && $past(cs_n_i) |-> so_oe_n_o && !so_o)
        else $error("output driven while deselected");
    a_so_fall: assert property ($changed(so_o) && !cs_n_i |-> !sclk_i)
        else $error("output moved while clock high");
endmodule

bind fisc_top fisc_monitor #(.T_SUS_NS(T_SUS_NS)) i_fisc_monitor (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .sclk_i      (sclk_i),
    .cs_n_i      (cs_n_i),
    .si_i        (si_i),
    .so_o        (so_o),
    .so_oe_n_o   (so_oe_n_o),
    .op_start_i  (op_start_i),
    .op_kind_i   (op_kind_i),
    .op_done_i   (op_done_i),
    .op_paused_i (op_paused_i),
    .op_pause_o  (op_pause_o),
    .op_resume_o (op_resume_o),
    .status_o    (status_o),
    .cmd_o       (cmd_o)
);

/* tb/fisc_host.sv */
// Host controller model that frames one opcode and gathers the serial reply.
`timescale 1ns/1ps
module fisc_host (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    // The clock stands still between frames and deep power-down is never entered.
    // A clean rise of chip select at start clears the serial side before reset ends.
    initial begin
        {sclk_o, cs_n_o, si_o} = 3'b000;
        #1 cs_n_o = 1'b1;
    end
    // Opcode goes MSB first, the reply is read at rises and a short count ends early.
    task automatic xfer(input logic [7:0] op, input int nbits, output logic [23:0] rd);
        rd = 24'h0;
        #3 cs_n_o = 1'b0;
        for (int i = 0; i < 8 + nbits; i++) begin
            si_o = (i < 8) ? op[7 - i] : ~si_o;
            #16 sclk_o = 1'b1;
            rd = (i < 8) ? rd : {rd[22:0], so_i};
            #16 sclk_o = 1'b0;
        end
        #16 cs_n_o = 1'b1;
        si_o = ~si_o;  // A released line must not show a stale bit.
        #20;
    endtask
endmodule

/* tb/fisc_tb_top.sv */
// Bench for the identity and suspend block with a host controller model.
`timescale 1ns/1ps
module fisc_tb_top;
    localparam int          T_SUS   = 200;
    localparam int          SUS_CYC = T_SUS * 250 / 1000;
    localparam logic [23:0] ID      = 24'h6e_21_c4;  // Value is arbitrary.
    localparam logic [7:0]  OK_ANY [19] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'hbb, 8'hbc, 8'h3b,
        8'h3c, 8'heb, 8'hec, 8'h6b, 8'h6c, 8'h05, 8'h35, 8'h15, 8'hc8, 8'hc5, 8'h66, 8'h99};
    localparam logic [7:0]  NO_ERS [9] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h20, 8'h52, 8'hd8,
        8'hc7, 8'h60};
    localparam logic [7:0]  OK_ERS [5] = '{8'h06, 8'h02, 8'h12, 8'h32, 8'h34};
    logic                    clk_i = 1'b0;
    logic                    rst_n_i = 1'b0;
    logic                    sclk, cs_n, si, so, so_oe_n, pause, resume, acc_q;
    logic [2:0]              eng_q = 3'h0;
    fisc_pkg::fisc_kind_t    kind = fisc_pkg::FISC_KIND_OTHER;
    fisc_pkg::fisc_status_t  status;
    fisc_pkg::fisc_cmd_evt_t cmd;
    int                      fails = 0, checks_done = 0, cyc = 0, seen = 0, res_seen = 0;
    always #2 clk_i = ~clk_i;
    fisc_top #(.ID_VALUE(ID), .T_SUS_NS(T_SUS)) i_fisc_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
        .op_start_i(eng_q[2]), .op_kind_i(kind), .op_done_i(eng_q[1]), .op_paused_i(eng_q[0]),
        .op_pause_o(pause), .op_resume_o(resume), .status_o(status), .cmd_o(cmd));
    fisc_host i_fisc_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (resume === 1'b1) begin
            res_seen <= res_seen + 1;
        end
        if ((cmd.accept | cmd.reject) === 1'b1) begin
            seen  <= seen + 1;
            acc_q <= cmd.accept;
        end
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic st(input logic [3:0] e);
        check("status and pause", 24'({status, pause}), {20'h0, e});
    endtask
    // One opcode per frame must give exactly one report with its code.
    task automatic cmd_op(input logic [7:0] op, input logic ok);
        logic [23:0] rd;
        int          n0;
        n0 = seen;
        i_fisc_host.xfer(op, 0, rd);
        for (int i = 0; i < 20 && seen == n0; i++) @(negedge clk_i);
        check("report count", 24'(seen - n0), 24'h1);
        check("report", {15'h0, cmd.code, acc_q}, {15'h0, op, ok});
    endtask
    task automatic eng(input logic [2:0] p, input fisc_pkg::fisc_kind_t k);
        @(posedge clk_i);
        eng_q <= p;
        kind  <= k;
        @(posedge clk_i);
        eng_q <= 3'h0;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic t_ident;
        logic [23:0] rd;
        i_fisc_host.xfer(8'h9f, 24, rd);
        check("identity", rd, ID);
        i_fisc_host.xfer(8'h9f, 12, rd);
        check("cut identity", rd, {12'h0, ID[23:12]});
        check("oe_n idle", {23'h0, so_oe_n}, 24'h1);
        cmd_op(8'h75, 1'b0);
        cmd_op(8'h7a, 1'b0);
        check("resume pulses", 24'(res_seen), 24'h0);
        cmd_op(8'h20, 1'b1);
        eng(3'h4, fisc_pkg::FISC_KIND_OTHER);
        cmd_op(8'h75, 1'b0);
        eng(3'h2, fisc_pkg::FISC_KIND_OTHER);
    endtask
    task automatic t_pgm;
        logic [23:0] rd;
        eng(3'h4, fisc_pkg::FISC_KIND_PGM);
        i_fisc_host.xfer(8'h9f, 24, rd);
        check("identity busy", rd, 24'h0);
        cmd_op(8'h75, 1'b1);
        st(4'hd);
        eng(3'h1, fisc_pkg::FISC_KIND_PGM);
        st(4'h5);
        foreach (NO_ERS[i]) cmd_op(NO_ERS[i], 1'b0);
        cmd_op(8'h02, 1'b0);
        cmd_op(8'h06, 1'b0);
        foreach (OK_ANY[i]) cmd_op(OK_ANY[i], 1'b1);
        cmd_op(8'h7a, 1'b1);
        check("resume pulses", 24'(res_seen), 24'h1);
        st(4'h8);
        eng(3'h2, fisc_pkg::FISC_KIND_PGM);
    endtask
    task automatic t_ers;
        eng(3'h4, fisc_pkg::FISC_KIND_ERS);
        cmd_op(8'h75, 1'b1);
        st(4'hb);
        repeat (SUS_CYC + 2) @(negedge clk_i);
        st(4'h3);
        foreach (NO_ERS[i]) cmd_op(NO_ERS[i], 1'b0);
        foreach (OK_ERS[i]) cmd_op(OK_ERS[i], 1'b1);
        eng(3'h4, fisc_pkg::FISC_KIND_PGM);
        cmd_op(8'h75, 1'b0);
        cmd_op(8'h7a, 1'b0);
        eng(3'h2, fisc_pkg::FISC_KIND_PGM);
        cmd_op(8'h7a, 1'b1);
        check("resume pulses", 24'(res_seen), 24'h2);
        st(4'h8);
    endtask
    task automatic t_power;
        cmd_op(8'h75, 1'b1);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(negedge clk_i);
        st(4'h0);
        cmd_op(8'h7a, 1'b0);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(negedge clk_i);
        t_ident();
        t_pgm();
        t_ers();
        t_power();
        results();
    end
endmodule
